// ===== hw/wwpc_pkg.sv
// Purpose: constants shared by the wakeup, watchdog and power control block
// Assumes: one 20 MHz clock; sfr bus of the 8051-style core
// Notes:   addresses are sfr byte addresses; indirect ones are 3-bit codes
package wwpc_pkg;
  // sfr addresses
  localparam logic [7:0] ADDR_CLKCFG  = 8'ha3;
  localparam logic [7:0] ADDR_PWRDWN  = 8'ha4;
  localparam logic [7:0] ADDR_WAKCFG  = 8'ha5;
  localparam logic [7:0] ADDR_USBSUS  = 8'ha6;
  localparam logic [7:0] ADDR_RADIO   = 8'ha7;
  localparam logic [7:0] ADDR_DATA_HI = 8'hab;
  localparam logic [7:0] ADDR_DATA_LO = 8'hac;
  localparam logic [7:0] ADDR_CTRL    = 8'had;
  localparam logic [7:0] ADDR_TICKDV  = 8'hb5;
  // reset values
  localparam logic [7:0] CLKCFG_RST   = 8'h80;
  localparam logic [7:0] TICKDV_RST   = 8'h03;
  localparam logic [7:0] WAKCFG_RST   = 8'h00;
  localparam logic [1:0] RADIO_RST    = 2'h0;
  // field positions
  localparam int CTRL_BUSY_BIT = 4;
  localparam int CTRL_RW_BIT   = 3;
  localparam int CLKCFG_PLL    = 7;
  localparam int PWRDWN_LF_BIT = 3;
  localparam int STA_RTC_BIT   = 8;
  // indirect addresses
  localparam logic [2:0] IA_WDOG   = 3'h0;
  localparam logic [2:0] IA_THIGH  = 3'h1;
  localparam logic [2:0] IA_TLOW   = 3'h2;
  localparam logic [2:0] IA_TVAL   = 3'h3;
  localparam logic [2:0] IA_PINLO  = 3'h4;
  localparam logic [2:0] IA_PINHI  = 3'h5;
  // wake configuration codes
  localparam logic [1:0] WC_IF_EN  = 2'h0;
  localparam logic [1:0] WC_ALWAYS = 2'h2;
  // power command values
  localparam logic [7:0] USB_SUSPEND = 8'h01;
  localparam logic [7:0] USB_RESUME  = 8'h00;
  // debounce lengths in debounce pulses (32 kHz pulse divided by latch+1)
  localparam logic [6:0] DEB_LEN1 = 7'd2;
  localparam logic [6:0] DEB_LEN2 = 7'd8;
  localparam logic [6:0] DEB_LEN3 = 7'd64;
  // timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned LF_HZ  = 32_000;
  localparam int unsigned LF_DIV = CLK_HZ / LF_HZ;
  localparam logic [9:0]  LF_DIV_M1  = 10'(LF_DIV - 1);
  localparam logic [9:0]  LF_DIV_HLF = 10'(LF_DIV / 2);
  typedef enum logic {XF_IDLE, XF_WAIT} wwpc_xfer_e;
endpackage

// ===== hw/wwpc_top.sv
// Purpose: always-on wakeup timer, watchdog, pin wakeup and power states
// Assumes: sfr strobes are one-cycle pulses; pins synchronous to i_clk
// Notes:   the slow side runs on enables derived from i_clk, no 2nd domain
`timescale 1ns/100ps

// What this block does
// - address 0 reads and loads watchdog count
// - address 1 reads timer and latch top bytes
// - address 1 writes debounce and latch top
// - address 2 accesses low latch sixteen bits
// - address 3 reads counter; write disables timer
// - addresses 4,5 read timer and pin status
// - address 4 writes selects of pins 3..0
// - address 5 writes selects of pins 5,4
// - control rw bit picks read or write
// - debounce codes need 0,2,8,64 stable pulses
// - edge codes off, rising, falling, both
// - mcu active at reset, standby on write
// - mcu wakes on usb, radio, pin, timer
// - usb suspend by write, resume by software/host
// - pll on at reset, software only when suspended
// - radio powered down at reset, software sets
// - programming pin high forces flash programming
// - pll follows usb and mcu state
// - pll multiplies 16 MHz to 48 MHz
// - 32 kHz clock derived, always running
// - control busy bit, address in bits 2:0
// - wake config: if enabled, always, ignore
// - timer wakes N+1..N+2 ticks, then every N+1
module wwpc_top #(
  parameter int NUM_PINS = 6
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_sfr_wr,
  input  wire logic       i_sfr_rd,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic [7:0] i_sfr_wdata,
  input  wire logic [5:0] i_pin,
  input  wire logic       i_flash_program_pin,
  input  wire logic       i_rf_irq,
  input  wire logic       i_usb_irq,
  input  wire logic       i_usb_wu,
  input  wire logic       i_usb_host_wake,
  input  wire logic [7:0] i_int_en1,
  output logic      [7:0] o_sfr_rdata,
  output logic            o_wdog_rst,
  output logic            o_wu_irq,
  output logic            o_mcu_standby,
  output logic            o_usb_suspend,
  output logic            o_pll_en,
  output logic            o_flash_flash_program_pin,
  output logic      [1:0] o_radio_mode,
  output logic            o_lf_clk
);
  import wwpc_pkg::*;

  if (NUM_PINS < 1 || NUM_PINS > 6) begin : g_bad_pins
    $error("NUM_PINS must be 1 to 6");
  end

  function automatic logic [6:0] deb_len(input logic [1:0] code);
    case (code)
      2'h1:    deb_len = DEB_LEN1;
      2'h2:    deb_len = DEB_LEN2;
      2'h3:    deb_len = DEB_LEN3;
      default: deb_len = 7'h00;
    endcase
  endfunction

  function automatic logic src_wake(input logic [1:0] cfg, input logic irq,
                                    input logic en);
    src_wake = irq && ((cfg == WC_IF_EN && en) || cfg == WC_ALWAYS);
  endfunction

  // slow time base
  logic [9:0]  lf_cnt_q,  lf_cnt_d;
  logic [7:0]  tick_cnt_q, tick_cnt_d;
  logic [3:0]  deb_pre_q, deb_pre_d;
  logic        lf_pulse,  tick, deb_pulse;
  // sfr registers
  logic [7:0]  data_hi_q, data_hi_d;
  logic [7:0]  data_lo_q, data_lo_d;
  logic [3:0]  ctrl_q,    ctrl_d;
  logic [7:0]  clkcfg_q,  clkcfg_d;
  logic [7:0]  wakcfg_q,  wakcfg_d;
  logic [7:0]  tickdv_q,  tickdv_d;
  logic [7:0]  rdata_q,   rdata_d;
  wwpc_xfer_e  xf_q,      xf_d;
  // slow-side state
  logic [15:0] wd_cnt_q,  wd_cnt_d;
  logic        wd_en_q,   wd_en_d;
  logic        wd_rst_q,  wd_rst_d;
  logic [23:0] rtc_cnt_q, rtc_cnt_d;
  logic [23:0] rtc_lat_q, rtc_lat_d;
  logic        rtc_en_q,  rtc_en_d;
  logic        rtc_sta_q, rtc_sta_d;
  logic [3:0]  deb_lat_q, deb_lat_d;
  logic [5:0]  pin_sta_q, pin_sta_d;
  logic [3:0]  pin_cfg_q [6];
  logic [3:0]  pin_cfg_d [6];
  logic [5:0]  pin_ev;
  logic        rtc_fire,  wu_ev;
  logic        wu_q,      wu_d;
  // power state
  logic        mcu_sb_q,  mcu_sb_d;
  logic        usb_sp_q,  usb_sp_d;
  logic        pll_q,     pll_d;
  logic        flash_program_pin_q,    flash_program_pin_d;
  logic [1:0]  radio_q,   radio_d;
  logic        lf_lvl_q,  lf_lvl_d;
  logic        wake;
  logic        rtc_arm_q, rtc_arm_d;
  logic [15:0] dpair;

  // time base: 32 kHz pulse, tick and debounce pulse
  always_comb begin
    lf_pulse   = (lf_cnt_q == LF_DIV_M1);
    lf_cnt_d   = lf_pulse ? 10'h000 : lf_cnt_q + 10'h001;
    lf_lvl_d   = (lf_cnt_d < LF_DIV_HLF);
    tick       = lf_pulse && (tick_cnt_q == tickdv_q);
    tick_cnt_d = tick_cnt_q;
    if (tick) begin
      tick_cnt_d = 8'h00;
    end else if (lf_pulse) begin
      tick_cnt_d = tick_cnt_q + 8'h01;
    end
    // debounce clock is the 32 kHz pulse divided by latch+1
    deb_pulse = lf_pulse && (deb_pre_q == deb_lat_q);
    deb_pre_d = deb_pre_q;
    if (deb_pulse) begin
      deb_pre_d = 4'h0;
    end else if (lf_pulse) begin
      deb_pre_d = deb_pre_q + 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lf_cnt_q   <= 10'h000;
      tick_cnt_q <= 8'h00;
      deb_pre_q  <= 4'h0;
      lf_lvl_q   <= 1'b1;
    end else begin
      lf_cnt_q   <= lf_cnt_d;
      tick_cnt_q <= tick_cnt_d;
      deb_pre_q  <= deb_pre_d;
      lf_lvl_q   <= lf_lvl_d;
    end
  end

  // per-pin debounce filter and edge detect
  for (genvar p = 0; p < 6; p++) begin : g_pin
    if (p < NUM_PINS) begin : g_used
      logic [6:0] cnt_q, cnt_d;
      logic       filt_q, filt_d;
      logic [6:0] len;
      always_comb begin
        len    = deb_len(pin_cfg_q[p][1:0]);
        filt_d = filt_q;
        cnt_d  = cnt_q;
        if (len == 7'h00) begin
          filt_d = i_pin[p];
          cnt_d  = 7'h00;
        end else if (i_pin[p] == filt_q) begin
          cnt_d = 7'h00;
        end else if (deb_pulse) begin
          if (cnt_q + 7'h01 >= len) begin
            filt_d = i_pin[p];
            cnt_d  = 7'h00;
          end else begin
            cnt_d = cnt_q + 7'h01;
          end
        end
        // edge code bit 2 selects rising, bit 3 falling
        pin_ev[p] = (filt_d != filt_q) && ((filt_d && pin_cfg_q[p][2])
                    || (!filt_d && pin_cfg_q[p][3]));
      end
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          cnt_q  <= 7'h00;
          filt_q <= 1'b0;
        end else begin
          cnt_q  <= cnt_d;
          filt_q <= filt_d;
        end
      end
    end else begin : g_none
      assign pin_ev[p] = 1'b0;
    end
  end

  // sfr access, indirect transfers, timers and watchdog
  always_comb begin
    data_hi_d = data_hi_q;
    data_lo_d = data_lo_q;
    ctrl_d    = ctrl_q;
    clkcfg_d  = clkcfg_q;
    wakcfg_d  = wakcfg_q;
    tickdv_d  = tickdv_q;
    radio_d   = radio_q;
    xf_d      = xf_q;
    wd_cnt_d  = wd_cnt_q;
    wd_en_d   = wd_en_q;
    wd_rst_d  = 1'b0;
    rtc_cnt_d = rtc_cnt_q;
    rtc_lat_d = rtc_lat_q;
    rtc_en_d  = rtc_en_q;
    rtc_sta_d = rtc_sta_q;
    deb_lat_d = deb_lat_q;
    pin_sta_d = pin_sta_q;
    for (int p = 0; p < 6; p++) begin
      pin_cfg_d[p] = pin_cfg_q[p];
    end
    rdata_d   = rdata_q;
    rtc_arm_d = rtc_arm_q;
    dpair     = {data_hi_q, data_lo_q};
    // watchdog counts ticks down; zero resets the whole mcu
    if (tick && wd_en_q) begin
      if (wd_cnt_q == 16'h0000) begin
        wd_rst_d = 1'b1;
      end else begin
        wd_cnt_d = wd_cnt_q - 16'h0001;
      end
    end
    rtc_fire = tick && rtc_en_q && !rtc_arm_q && (rtc_cnt_q == 24'h000000);
    if (tick && rtc_en_q && rtc_arm_q) begin
      // first tick after a load is partial; skipping it gives N+1 to N+2
      rtc_arm_d = 1'b0;
    end else if (tick && rtc_en_q) begin
      // reload at zero gives one wakeup every N+1 ticks
      rtc_cnt_d = rtc_fire ? rtc_lat_q : rtc_cnt_q - 24'h000001;
    end
    // slow side completes the transfer on the next 32 kHz pulse
    case (xf_q)
      XF_IDLE: xf_d = XF_IDLE;
      XF_WAIT: begin
        if (lf_pulse) begin
          xf_d = XF_IDLE;
          if (ctrl_q[CTRL_RW_BIT]) begin
            if (ctrl_q[2:0] == IA_WDOG) begin
              wd_cnt_d = dpair;
              wd_en_d  = 1'b1;
            end else if (ctrl_q[2:0] == IA_THIGH) begin
              deb_lat_d        = data_hi_q[3:0];
              rtc_lat_d[23:16] = data_lo_q;
            end else if (ctrl_q[2:0] == IA_TLOW) begin
              rtc_lat_d[15:0] = dpair;
              rtc_cnt_d       = {rtc_lat_q[23:16], dpair};
              rtc_en_d        = 1'b1;
              rtc_arm_d       = 1'b1;
            end else if (ctrl_q[2:0] == IA_TVAL) begin
              rtc_en_d = 1'b0;
            end else if (ctrl_q[2:0] == IA_PINLO) begin
              for (int p = 0; p < 4; p++) begin
                if (p < NUM_PINS) begin
                  pin_cfg_d[p] = dpair[4*p +: 4];
                end
              end
            end else if (ctrl_q[2:0] == IA_PINHI) begin
              for (int p = 4; p < 6; p++) begin
                if (p < NUM_PINS) begin
                  pin_cfg_d[p] = data_lo_q[4*(p-4) +: 4];
                end
              end
            end
            // reserved codes write nothing
          end else begin
            if (ctrl_q[2:0] == IA_WDOG) begin
              {data_hi_d, data_lo_d} = wd_cnt_q;
            end else if (ctrl_q[2:0] == IA_THIGH) begin
              {data_hi_d, data_lo_d} = {rtc_cnt_q[23:16], rtc_lat_q[23:16]};
            end else if (ctrl_q[2:0] == IA_TLOW) begin
              {data_hi_d, data_lo_d} = rtc_lat_q[15:0];
            end else if (ctrl_q[2:0] == IA_TVAL) begin
              {data_hi_d, data_lo_d} = rtc_cnt_q[15:0];
            end else if (ctrl_q[2:0] == IA_PINLO || ctrl_q[2:0] == IA_PINHI) begin
              data_hi_d = {7'h00, rtc_sta_q};
              data_lo_d = {2'h0, pin_sta_q};
              rtc_sta_d = 1'b0;
              pin_sta_d = 6'h00;
            end else begin
              {data_hi_d, data_lo_d} = 16'h0000;
            end
          end
        end
      end
      default: xf_d = XF_IDLE;
    endcase
    // events set after the read clears, so a same-cycle event survives
    if (rtc_fire) begin
      rtc_sta_d = 1'b1;
    end
    pin_sta_d = pin_sta_d | pin_ev;
    if (i_sfr_wr) begin
      if (i_sfr_addr == ADDR_DATA_HI) begin
        data_hi_d = i_sfr_wdata;
      end else if (i_sfr_addr == ADDR_DATA_LO) begin
        data_lo_d = i_sfr_wdata;
      end else if (i_sfr_addr == ADDR_CTRL) begin
        ctrl_d = i_sfr_wdata[3:0];
        xf_d   = XF_WAIT;
      end else if (i_sfr_addr == ADDR_CLKCFG) begin
        clkcfg_d = {i_sfr_wdata[7:4], 2'h0, i_sfr_wdata[1:0]};
      end else if (i_sfr_addr == ADDR_WAKCFG) begin
        wakcfg_d = i_sfr_wdata;
      end else if (i_sfr_addr == ADDR_TICKDV) begin
        tickdv_d = i_sfr_wdata;
      end else if (i_sfr_addr == ADDR_RADIO) begin
        radio_d = i_sfr_wdata[1:0];
      end
    end
    if (i_sfr_rd) begin
      if (i_sfr_addr == ADDR_DATA_HI) begin
        rdata_d = data_hi_q;
      end else if (i_sfr_addr == ADDR_DATA_LO) begin
        rdata_d = data_lo_q;
      end else if (i_sfr_addr == ADDR_CTRL) begin
        rdata_d = {3'h0, xf_q == XF_WAIT, ctrl_q};
      end else if (i_sfr_addr == ADDR_CLKCFG) begin
        rdata_d = clkcfg_q;
      end else if (i_sfr_addr == ADDR_PWRDWN) begin
        rdata_d = 8'(lf_lvl_q) << PWRDWN_LF_BIT;
      end else if (i_sfr_addr == ADDR_WAKCFG) begin
        rdata_d = wakcfg_q;
      end else if (i_sfr_addr == ADDR_USBSUS) begin
        rdata_d = {7'h00, usb_sp_q};
      end else if (i_sfr_addr == ADDR_RADIO) begin
        rdata_d = {6'h00, radio_q};
      end else if (i_sfr_addr == ADDR_TICKDV) begin
        rdata_d = tickdv_q;
      end else begin
        rdata_d = 8'h00;
      end
    end
    wu_ev = rtc_fire || (|pin_ev);
    wu_d  = wu_ev;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      data_hi_q <= 8'h00;
      data_lo_q <= 8'h00;
      ctrl_q    <= 4'h0;
      clkcfg_q  <= CLKCFG_RST;
      wakcfg_q  <= WAKCFG_RST;
      tickdv_q  <= TICKDV_RST;
      radio_q   <= RADIO_RST;
      rdata_q   <= 8'h00;
      xf_q      <= XF_IDLE;
      wd_cnt_q  <= 16'h0000;
      wd_en_q   <= 1'b0;
      wd_rst_q  <= 1'b0;
      rtc_cnt_q <= 24'h000000;
      rtc_lat_q <= 24'h000000;
      rtc_en_q  <= 1'b0;
      rtc_arm_q <= 1'b0;
      rtc_sta_q <= 1'b0;
      deb_lat_q <= 4'h0;
      pin_sta_q <= 6'h00;
      wu_q      <= 1'b0;
      for (int p = 0; p < 6; p++) begin
        pin_cfg_q[p] <= 4'h0;
      end
    end else begin
      data_hi_q <= data_hi_d;
      data_lo_q <= data_lo_d;
      ctrl_q    <= ctrl_d;
      clkcfg_q  <= clkcfg_d;
      wakcfg_q  <= wakcfg_d;
      tickdv_q  <= tickdv_d;
      radio_q   <= radio_d;
      rdata_q   <= rdata_d;
      xf_q      <= xf_d;
      wd_cnt_q  <= wd_cnt_d;
      wd_en_q   <= wd_en_d;
      wd_rst_q  <= wd_rst_d;
      rtc_cnt_q <= rtc_cnt_d;
      rtc_lat_q <= rtc_lat_d;
      rtc_en_q  <= rtc_en_d;
      rtc_arm_q <= rtc_arm_d;
      rtc_sta_q <= rtc_sta_d;
      deb_lat_q <= deb_lat_d;
      pin_sta_q <= pin_sta_d;
      wu_q      <= wu_d;
      for (int p = 0; p < 6; p++) begin
        pin_cfg_q[p] <= pin_cfg_d[p];
      end
    end
  end

  // power states
  always_comb begin
    wake = src_wake(wakcfg_q[7:6], i_rf_irq, i_int_en1[1])
        || src_wake(wakcfg_q[5:4], wu_q, i_int_en1[5])
        || src_wake(wakcfg_q[3:2], i_usb_irq, i_int_en1[4])
        || src_wake(wakcfg_q[1:0], i_usb_wu, i_int_en1[3]);
    mcu_sb_d = mcu_sb_q;
    if (wake) begin
      mcu_sb_d = 1'b0;
    end else if (i_sfr_wr && i_sfr_addr == ADDR_PWRDWN && i_sfr_wdata[2:0] != 3'h0) begin
      mcu_sb_d = 1'b1;
    end
    usb_sp_d = usb_sp_q;
    if (i_usb_host_wake) begin
      usb_sp_d = 1'b0;
    end else if (i_sfr_wr && i_sfr_addr == ADDR_USBSUS) begin
      if (i_sfr_wdata == USB_SUSPEND) begin
        usb_sp_d = 1'b1;
      end else if (i_sfr_wdata == USB_RESUME) begin
        usb_sp_d = 1'b0;
      end
    end
    // pll feeds the x3 multiplier that makes 48 MHz from 16 MHz
    if (!usb_sp_d) begin
      pll_d = 1'b1;
    end else if (mcu_sb_d) begin
      pll_d = 1'b0;
    end else begin
      pll_d = clkcfg_d[CLKCFG_PLL];
    end
    flash_program_pin_d = i_flash_program_pin;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mcu_sb_q <= 1'b0;
      usb_sp_q <= 1'b0;
      pll_q    <= 1'b1;
      flash_program_pin_q   <= 1'b0;
    end else begin
      mcu_sb_q <= mcu_sb_d;
      usb_sp_q <= usb_sp_d;
      pll_q    <= pll_d;
      flash_program_pin_q   <= flash_program_pin_d;
    end
  end

  assign o_sfr_rdata   = rdata_q;
  assign o_wdog_rst    = wd_rst_q;
  assign o_wu_irq      = wu_q;
  assign o_mcu_standby = mcu_sb_q;
  assign o_usb_suspend = usb_sp_q;
  assign o_pll_en      = pll_q;
  assign o_flash_flash_program_pin  = flash_program_pin_q;
  assign o_radio_mode  = radio_q;
  assign o_lf_clk      = lf_lvl_q;
endmodule

// ===== bench/wwpc_mcu_model.sv
// Purpose: mcu side of the sfr bus, byte and indirect transfers
// Assumes: strobes launched on falling edges, one cycle each
// Notes:   busy poll waits on; the bench timeout catches a stuck transfer
`timescale 1ns/100ps
module wwpc_mcu_model
  import wwpc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    // released data must not keep looking valid
    o_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    d = i_rdata;
  endtask

  // stop the core only through the power-down register
  task automatic sleep();
    wr(ADDR_PWRDWN, 8'h01);
  endtask

  // callers stay below code 6 unless probing on purpose
  task automatic ind(input logic w, input logic [2:0] ia, input logic [15:0] wd,
                     output logic [15:0] q);
    logic [7:0] b;
    if (w) begin
      wr(ADDR_DATA_HI, wd[15:8]);
      wr(ADDR_DATA_LO, wd[7:0]);
    end
    wr(ADDR_CTRL, {4'h0, w, ia});
    b = 8'hff;
    while (b[CTRL_BUSY_BIT] !== 1'b0) begin
      rd(ADDR_CTRL, b);
    end
    rd(ADDR_DATA_HI, q[15:8]);
    rd(ADDR_DATA_LO, q[7:0]);
  endtask
endmodule

// ===== bench/wwpc_top_monitor.sv
// Purpose: port-level checks of the wakeup, watchdog and power block
// Assumes: bound to wwpc_top; one clock domain
// Notes:   wake inputs guard the standby check since a wake wins a tie
`timescale 1ns/100ps
module wwpc_top_monitor
  import wwpc_pkg::*;
#(
  parameter int NUM_PINS = 6
) (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_sfr_wr,
  input wire logic       i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic       i_rf_irq,
  input wire logic       i_usb_irq,
  input wire logic       i_usb_wu,
  input wire logic       i_usb_host_wake,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       o_wu_irq,
  input wire logic       o_mcu_standby,
  input wire logic       o_usb_suspend,
  input wire logic       o_pll_en,
  input wire logic       o_flash_flash_program_pin,
  input wire logic [1:0] o_radio_mode,
  input wire logic       o_lf_clk
);
  logic       wake_in;
  logic       lf_rise;
  logic [9:0] lf_n_q;
  logic       lf_p_q;
  logic       lf_seen_q;

  assign wake_in = i_rf_irq | i_usb_irq | i_usb_wu | o_wu_irq;
  assign lf_rise = o_lf_clk & ~lf_p_q;

  // armed after the first rise, the count from reset to it is 625, one more than later periods
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lf_n_q <= 10'h000;
      lf_p_q <= 1'b1;
      lf_seen_q <= 1'b0;
    end else begin
      lf_p_q <= o_lf_clk;
      lf_n_q <= lf_rise ? 10'h000 : lf_n_q + 10'h001;
      lf_seen_q <= lf_seen_q | lf_rise;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_sleep_cmd;
    i_sfr_wr && i_sfr_addr == ADDR_PWRDWN && i_sfr_wdata == 8'h01 && !wake_in;
  endsequence
  sequence s_susp_active;
    o_usb_suspend && !o_mcu_standby && !o_flash_flash_program_pin && !i_usb_host_wake;
  endsequence
  sequence s_pll_off_wr;
    i_sfr_wr && i_sfr_addr == ADDR_CLKCFG && !i_sfr_wdata[CLKCFG_PLL] && !wake_in;
  endsequence

  property p_rst_state;
    $fell(i_rst) |-> o_pll_en && !o_mcu_standby && !o_usb_suspend && o_radio_mode == 2'h0;
  endproperty
  property p_sleep;
    s_sleep_cmd |=> o_mcu_standby;
  endproperty
  property p_usb_susp;
    i_sfr_wr && i_sfr_addr == ADDR_USBSUS && i_sfr_wdata == USB_SUSPEND
      && !i_usb_host_wake |=> o_usb_suspend;
  endproperty
  property p_host_wake;
    i_usb_host_wake && !i_sfr_wr |=> !o_usb_suspend;
  endproperty
  property p_pll_on;
    !o_flash_flash_program_pin && !o_usb_suspend |-> o_pll_en;
  endproperty
  property p_pll_off;
    !o_flash_flash_program_pin && o_usb_suspend && o_mcu_standby |-> !o_pll_en;
  endproperty
  property p_pll_sw;
    s_susp_active ##0 s_pll_off_wr |=> !o_pll_en;
  endproperty
  property p_radio;
    i_sfr_wr && i_sfr_addr == ADDR_RADIO |=> o_radio_mode == $past(i_sfr_wdata[1:0]);
  endproperty
  property p_unmapped;
    i_sfr_rd && i_sfr_addr == 8'h00 |=> o_sfr_rdata == 8'h00;
  endproperty
  property p_lf_period;
    lf_rise && lf_seen_q |-> lf_n_q == LF_DIV_M1;
  endproperty

  a_rst_state:
    assert property (p_rst_state) else $error("power state after reset wrong");
  a_sleep:
    assert property (p_sleep) else $error("standby not entered");
  a_usb_susp:
    assert property (p_usb_susp) else $error("usb suspend not entered");
  a_host_wake:
    assert property (p_host_wake) else $error("host wake ignored");
  a_pll_on:
    assert property (p_pll_on) else $error("pll off with usb active");
  a_pll_off:
    assert property (p_pll_off) else $error("pll on in suspend and standby");
  a_pll_sw:
    assert property (p_pll_sw) else $error("pll enable bit not obeyed");
  a_radio:
    assert property (p_radio) else $error("radio mode not taken");
  a_unmapped:
    assert property (p_unmapped) else $error("unmapped read not zero");
  a_lf_period:
    assert property (p_lf_period) else $error("low frequency period wrong");
endmodule

bind wwpc_top wwpc_top_monitor #(.NUM_PINS(NUM_PINS)) u_mon (
  .i_clk, .i_rst, .i_sfr_wr, .i_sfr_rd, .i_sfr_addr, .i_sfr_wdata, .i_rf_irq,
  .i_usb_irq, .i_usb_wu, .i_usb_host_wake, .o_sfr_rdata, .o_wu_irq, .o_mcu_standby,
  .o_usb_suspend, .o_pll_en, .o_flash_flash_program_pin, .o_radio_mode, .o_lf_clk);

// ===== bench/tb.sv
// Purpose: self-checking bench of the wakeup, watchdog and power block
// Assumes: inputs change on falling edges; 20 MHz clock
// Notes:   tick is 4 lf pulses (2500 cycles) from the divider reset value
`timescale 1ns/100ps
module tb;
  import wwpc_pkg::*;
  typedef struct {
    logic [1:0] s;
    logic [7:0] cf;
    logic [7:0] en;
    logic       ex;
  } wwpc_row_s;
  localparam int TICK = 2500;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        flash_program_pin = 1'b0;
  logic        hw = 1'b0;
  logic [2:0]  src = 3'h0;
  logic [5:0]  pin = 6'h00;
  logic [7:0]  ien = 8'h00;
  logic        wr, rd, sb, sus, pll, fp, wu, wdr;
  logic [7:0]  addr, wd, rdata, b;
  logic [1:0]  radio;
  logic [15:0] q, q2;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          t0, t1;
  // source 0 rf, 1 usb irq, 2 usb wakeup; config, enable byte, standby kept
  wwpc_row_s   rows [8] = '{
    '{2'd0, 8'hc0, 8'hff, 1'b1}, '{2'd0, 8'h00, 8'h00, 1'b1},
    '{2'd0, 8'h00, 8'h02, 1'b0}, '{2'd0, 8'h80, 8'h00, 1'b0},
    '{2'd1, 8'h0c, 8'hff, 1'b1}, '{2'd1, 8'h00, 8'h10, 1'b0},
    '{2'd2, 8'h03, 8'hff, 1'b1}, '{2'd2, 8'h02, 8'h00, 1'b0}};

  wwpc_top uut (
    .i_clk(clk), .i_rst(rst), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_addr(addr),
    .i_sfr_wdata(wd), .i_pin(pin), .i_flash_program_pin(flash_program_pin), .i_rf_irq(src[0]), .i_usb_irq(src[1]),
    .i_usb_wu(src[2]), .i_usb_host_wake(hw), .i_int_en1(ien), .o_sfr_rdata(rdata),
    .o_wdog_rst(wdr), .o_wu_irq(wu), .o_mcu_standby(sb), .o_usb_suspend(sus),
    .o_pll_en(pll), .o_flash_flash_program_pin(fp), .o_radio_mode(radio), .o_lf_clk());
  wwpc_mcu_model mcu (
    .i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wd));

  initial begin
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      results();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic do_reset(input int n);
    rst = 1'b1;
    cycles(n);
    rst = 1'b0;
    chk({sb, sus, pll, fp, radio}, 16'h0008);
  endtask

  // waits for a wake pulse, bounded; ex says whether one is due
  task automatic expw(input int lim, input logic ex);
    int c;
    c = 0;
    while (wu !== 1'b1 && c < lim) begin
      @(negedge clk);
      c++;
    end
    chk(c < lim, ex);
    @(negedge clk);
  endtask

  initial begin
    do_reset(5);
    foreach (rows[i]) begin
      mcu.wr(ADDR_WAKCFG, rows[i].cf);
      ien = rows[i].en;
      mcu.sleep();
      chk(sb, 1'b1);
      src[rows[i].s] = 1'b1;
      cycles(4);
      chk(sb, rows[i].ex);
      src = 3'h0;
      mcu.wr(ADDR_WAKCFG, 8'haa);
      src = 3'h7;
      cycles(2);
      src = 3'h0;
      chk(sb, 1'b0);
    end
    mcu.rd(ADDR_WAKCFG, b);
    chk(b, 8'haa);
    mcu.wr(ADDR_CLKCFG, 8'hff);
    mcu.rd(ADDR_CLKCFG, b);
    chk(b, 8'hf3);
    mcu.rd(8'h00, b);
    chk(b, 8'h00);
    // usb suspend hands the pll to software, standby forces it off
    mcu.wr(ADDR_USBSUS, USB_SUSPEND);
    chk({sus, pll}, 2'b11);
    mcu.wr(ADDR_CLKCFG, 8'h73);
    chk(pll, 1'b0);
    mcu.wr(ADDR_CLKCFG, 8'hf3);
    mcu.sleep();
    chk(pll, 1'b0);
    src = 3'h7;
    cycles(2);
    src = 3'h0;
    chk({sb, pll}, 2'b01);
    hw = 1'b1;
    cycles(1);
    hw = 1'b0;
    cycles(1);
    chk({sus, pll}, 2'b01);
    mcu.wr(ADDR_RADIO, 8'h02);
    chk(radio, 2'h2);
    flash_program_pin = 1'b1;
    cycles(2);
    chk(fp, 1'b1);
    flash_program_pin = 1'b0;
    mcu.ind(1'b1, IA_WDOG, 16'h1234, q);
    mcu.ind(1'b0, IA_WDOG, 16'h0000, q);
    chk(q[15:8], 8'h12);
    mcu.ind(1'b1, IA_THIGH, 16'hf0a7, q);
    mcu.ind(1'b1, IA_TLOW, 16'hbeef, q);
    mcu.ind(1'b0, IA_THIGH, 16'h0000, q);
    chk(q, 16'ha7a7);
    mcu.ind(1'b0, IA_TLOW, 16'h0000, q);
    chk(q, 16'hbeef);
    mcu.ind(1'b1, IA_TVAL, 16'hffff, q);
    mcu.ind(1'b0, IA_TVAL, 16'h0000, q);
    chk(q[15:8], 8'hbe);
    cycles(2 * TICK);
    mcu.ind(1'b0, IA_TVAL, 16'h0000, q2);
    chk(q2, q);
    mcu.ind(1'b0, 3'h6, 16'h0000, q);
    chk(q, 16'h0000);
    // reload of one: first wake two to three ticks on, then every two
    mcu.ind(1'b1, IA_THIGH, 16'h0000, q);
    mcu.ind(1'b1, IA_TLOW, 16'h0001, q);
    t0 = cyc;
    expw(8000, 1'b1);
    t1 = cyc;
    chk(t1 - t0 >= 2 * TICK - 10 && t1 - t0 <= 3 * TICK + 10, 1'b1);
    expw(6000, 1'b1);
    chk(16'(cyc - t1), 16'(2 * TICK));
    mcu.ind(1'b0, IA_PINHI, 16'h0000, q);
    chk(q, 16'h0100);
    mcu.ind(1'b0, IA_PINLO, 16'h0000, q);
    chk(q, 16'h0000);
    mcu.ind(1'b1, IA_TVAL, 16'h0000, q);
    // pin0 rising, pin1 falling with two-pulse filter, pin5 both edges
    mcu.ind(1'b1, IA_PINLO, 16'h0094, q);
    mcu.ind(1'b1, IA_PINHI, 16'hffd0, q);
    pin[0] = 1'b1;
    expw(2000, 1'b1);
    pin[0] = 1'b0;
    expw(3000, 1'b0);
    pin[1] = 1'b1;
    expw(3000, 1'b0);
    pin[1] = 1'b0;
    cycles(300);
    pin[1] = 1'b1;
    expw(3000, 1'b0);
    pin[1] = 1'b0;
    expw(4000, 1'b1);
    pin[5] = 1'b1;
    expw(2000, 1'b1);
    pin[5] = 1'b0;
    expw(2000, 1'b1);
    mcu.ind(1'b0, IA_PINLO, 16'h0000, q);
    chk(q, 16'h0023);
    mcu.ind(1'b0, IA_PINHI, 16'h0000, q);
    chk(q, 16'h0000);
    mcu.ind(1'b1, IA_WDOG, 16'h0000, q);
    t0 = 0;
    repeat (2 * TICK) @(negedge clk) t0 += wdr;
    chk(16'(t0), 16'h0002);
    mcu.wr(ADDR_USBSUS, USB_SUSPEND);
    mcu.wr(ADDR_RADIO, 8'h03);
    do_reset(2);
    results();
  end
endmodule
